// file: io_cmd_pkg.sv
/*
  Shared constants for the digital and analog I/O command block: the APB
  register offsets, the field positions inside the command words, the widths
  and the reset values.
  Assumes a 32-bit APB with every register on one aligned word.
*/
package io_cmd_pkg;

  // Sizes of the I/O resources
  localparam int DIO_W      = 16;         // Digital outputs and inputs
  localparam int BANK_W     = 8;          // Bits in one digital bank
  localparam int ACH_N      = 8;          // Analog channels per direction
  localparam int ACH_W      = 3;          // Analog channel number width
  localparam int CODE_W     = 12;         // Converter resolution
  localparam int RNG_W      = 2;          // Range select width
  localparam int AI_SCALE_SH = 3;         // Integer input code is code times 8

  // Register byte offsets
  localparam logic [7:0] OFF_DOUT    = 8'h00; // Bank write, both banks
  localparam logic [7:0] OFF_SET     = 8'h04; // Set one output
  localparam logic [7:0] OFF_CLR     = 8'h08; // Clear one output
  localparam logic [7:0] OFF_COND    = 8'h0c; // Conditional output write
  localparam logic [7:0] OFF_OUT_RB  = 8'h10; // Single output readback
  localparam logic [7:0] OFF_IN_RD   = 8'h14; // Single input read
  localparam logic [7:0] OFF_POL     = 8'h18; // Per-input active level
  localparam logic [7:0] OFF_BANK    = 8'h1c; // Bank status read
  localparam logic [7:0] OFF_DTRIP   = 8'h20; // Digital trip point
  localparam logic [7:0] OFF_AICFG   = 8'h24; // Analog input mode and range
  localparam logic [7:0] OFF_AOCFG   = 8'h28; // Analog output range
  localparam logic [7:0] OFF_ATRIP   = 8'h2c; // Analog trip point
  localparam logic [7:0] OFF_AOSET   = 8'h30; // Analog output write
  localparam logic [7:0] OFF_AO_RB   = 8'h34; // Analog output readback
  localparam logic [7:0] OFF_AI_RD   = 8'h38; // Analog input voltage code
  localparam logic [7:0] OFF_AI_INT  = 8'h3c; // Analog input integer code
  localparam logic [7:0] OFF_STATUS  = 8'h40; // Hold flags

  // Field positions
  localparam int SEL_LSB     = 0;         // Bit, bank or channel number
  localparam int COND_OP_LSB = 4;         // Conditional operand, bits 31:4
  localparam int BANK1_LSB   = 8;         // Bank 1 in the bank write word
  localparam int LVL_LSB     = 16;        // Required levels of the trip
  localparam int DIFF_BIT    = 0;         // Differential input mode
  localparam int AIRNG_LSB   = 1;         // Input range select
  localparam int DIR_BIT     = 4;         // Analog trip direction
  localparam int CODE_LSB    = 16;        // Threshold or output code
  localparam int ST_DHOLD    = 0;         // Digital hold active
  localparam int ST_AHOLD    = 1;         // Analog hold active

  // Reset values
  localparam logic [15:0] DOUT_RST = 16'h0000; // All outputs off
  localparam logic [15:0] POL_RST  = 16'h0000; // High is active
  localparam logic        DIFF_RST = 1'b0;     // Single-ended is default

endpackage : io_cmd_pkg

// file: dac_store.sv
/*
  Small memory holding the last code written to each analog output channel.
  Read data comes out of a register one edge after the address.
  Assumes one writer and one reader on the same clock.
*/
`timescale 1ns/10ps
module dac_store
  import io_cmd_pkg::*;
(
  input  wire logic                mclk,   // Block clock
  input  wire logic                we,     // Write strobe
  input  wire logic [ACH_W-1:0]    waddr,  // Channel written
  input  wire logic [CODE_W-1:0]   wdata,  // Code written
  input  wire logic [ACH_W-1:0]    raddr,  // Channel read
  output logic      [CODE_W-1:0]   rdata   // Registered read data
);

  // Storage, one word per channel
  logic [CODE_W-1:0] mem [ACH_N];

  // Write port; no reset so it maps onto plain memory cells
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read; a same-edge write shows one edge later
  always_ff @(posedge mclk) begin
    rdata <= mem[raddr];
  end

endmodule : dac_store

// file: io_cmd.sv
/*
  APB-reached I/O command logic: sixteen digital outputs in two banks,
  sixteen digital inputs with selectable active level, trip-point holds on
  digital and analog inputs, and eight analog channels each way.
  Assumes inputs synchronous to mclk and an external converter that delivers
  eight 12-bit input codes and takes one output update at a time.
*/
// Overview of operation
// - Set and clear drive one output
// - Conditional write sets if operand nonzero
// - Bank write loads outputs, bit k drives k
// - First operand bank 0, second bank 1
// - Any single output state reads back
// - Single input read returns selected level
// - Per-input active level setting
// - Bank status read returns whole bank
// - Digital hold until input combination met
// - Analog input read gives 12-bit code
// - Integer input code is code times eight
// - Inputs single-ended or four differential
// - Input range selectable by configuration
// - Analog hold until rise or fall
// - Condition already met skips the hold
// - Analog output write and readback
// - Analog outputs are 12-bit
// - Integer output code unscaled
// - Separate output range setting
`timescale 1ns/10ps
module io_cmd
  import io_cmd_pkg::*;
(
  input  wire logic                      mclk,         // Block clock, 250 MHz
  input  wire logic                      rst,          // Async reset, high
  input  wire logic                      psel,         // APB select
  input  wire logic                      penable,      // APB access phase
  input  wire logic                      pwrite,       // APB direction
  input  wire logic [7:0]                paddr,        // APB byte address
  input  wire logic [31:0]               pwdata,       // APB write data
  output logic      [31:0]               prdata,       // APB read data
  output logic                           pready,       // APB ready
  output logic                           pslverr,      // APB error
  input  wire logic [DIO_W-1:0]          din,          // Digital input pins
  output logic      [DIO_W-1:0]          dout,         // Digital output pins
  input  wire logic [ACH_N*CODE_W-1:0]   adc_code,     // Input codes, ch 0 low
  output logic                           ai_diff_mode, // Differential inputs
  output logic      [RNG_W-1:0]          ai_range,     // Input range select
  output logic      [RNG_W-1:0]          ao_range,     // Output range select
  output logic                           dac_wr,       // Output update pulse
  output logic      [ACH_W-1:0]          dac_ch,       // Output channel
  output logic      [CODE_W-1:0]         dac_code,     // Output code
  output logic                           digital_hold, // Digital trip waiting
  output logic                           voltage_hold  // Analog trip waiting
);

  // All block state
  typedef struct packed {
    logic [DIO_W-1:0]  dout;      // Output register
    logic [DIO_W-1:0]  pol;       // One means input active when low
    logic [3:0]        osel;      // Output readback selection
    logic [3:0]        isel;      // Input read selection
    logic              bsel;      // Bank status selection
    logic [DIO_W-1:0]  dmask;     // Inputs taking part in the trip
    logic [DIO_W-1:0]  dlvl;      // Required level per input
    logic              dwait;     // Digital hold active
    logic              diff;      // Differential input mode
    logic [RNG_W-1:0]  airng;     // Input range
    logic [RNG_W-1:0]  aorng;     // Output range
    logic [ACH_W-1:0]  aisel;     // Analog input read selection
    logic [ACH_W-1:0]  tch;       // Analog trip channel
    logic              tdir;      // Zero rise, one fall
    logic [CODE_W-1:0] thr;       // Analog trip threshold
    logic              await_;    // Analog hold active
    logic [ACH_W-1:0]  aosel;     // Analog output readback selection
    logic              dac_wr;    // Output update pulse
    logic [ACH_W-1:0]  dac_ch;    // Output channel
    logic [CODE_W-1:0] dac_code;  // Output code
    logic [31:0]       prdata;    // Read data register
    logic              pready;    // Ready register
    logic              pslverr;   // Error register
  } regs_s;

  regs_s st;                       // Present state
  regs_s next_st;                  // Next state

  logic                wr_acc;     // Write taking effect this edge
  logic                rd_setup;   // Read setup cycle
  logic [DIO_W-1:0]    act;        // Inputs after active-level mapping
  logic [ACH_W-1:0]    ai_ch;      // Read channel, trimmed in diff mode
  logic [ACH_W-1:0]    at_ch;      // Trip channel, trimmed in diff mode
  logic [CODE_W-1:0]   ai_val;     // Selected input code
  logic [CODE_W-1:0]   at_val;     // Trip channel code
  logic [CODE_W-1:0]   new_thr;    // Threshold being armed
  logic [ACH_W-1:0]    new_ch;     // Trip channel being armed
  logic                dmet;       // Digital combination met now
  logic                amet;       // Analog condition met on live trip
  logic                amet_new;   // Analog condition met at arm
  logic [CODE_W-1:0]   ao_rdata;   // Stored output code
  logic [CODE_W-1:0]   new_code;   // Code field of the write word

  // Transfer phases; writes act only at the access edge
  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  // Active-level mapping of the digital inputs
  assign act = din ^ st.pol;

  // Differential mode leaves four channels, so the top number bit is dropped
  assign ai_ch  = st.diff ? {1'b0, st.aisel[1:0]} : st.aisel;
  assign at_ch  = st.diff ? {1'b0, st.tch[1:0]} : st.tch;
  assign new_ch = pwdata[SEL_LSB +: ACH_W];
  assign ai_val = adc_code[ai_ch*CODE_W +: CODE_W];
  assign at_val = adc_code[at_ch*CODE_W +: CODE_W];
  assign new_thr  = pwdata[CODE_LSB +: CODE_W];
  assign new_code = pwdata[CODE_LSB +: CODE_W];

  // Every listed input at its required level; unlisted inputs are free
  assign dmet = ((act ~^ st.dlvl) & st.dmask) == st.dmask;

  // Rise waits for above, fall for below the threshold
  assign amet = st.tdir ? (at_val < st.thr) : (at_val > st.thr);

  // Condition as seen by the command that arms the trip
  always_comb begin
    logic [ACH_W-1:0]  ch;
    logic [CODE_W-1:0] v;
    ch = st.diff ? {1'b0, new_ch[1:0]} : new_ch;
    v  = adc_code[ch*CODE_W +: CODE_W];
    amet_new = pwdata[DIR_BIT] ? (v < new_thr) : (v > new_thr);
  end

  // Stored analog output codes; read address follows the next selection
  dac_store u_store (
    .mclk  (mclk),
    .we    (wr_acc && paddr == OFF_AOSET),
    .waddr (new_ch),
    .wdata (new_code),
    .raddr (next_st.aosel),
    .rdata (ao_rdata)
  );

  // Next-state logic: register writes, holds and the read data register
  always_comb begin
    next_st        = st;
    next_st.dac_wr = 1'b0;                 // Update is a one-cycle pulse
    next_st.pready = 1'b0;

    // Holds release once their condition is met
    if (st.dwait && dmet) begin
      next_st.dwait = 1'b0;
    end
    if (st.await_ && amet) begin
      next_st.await_ = 1'b0;
    end

    // Register writes
    if (wr_acc) begin
      case (paddr)
        OFF_DOUT: begin
          next_st.dout[0 +: BANK_W]         = pwdata[0 +: BANK_W];
          next_st.dout[BANK1_LSB +: BANK_W] = pwdata[BANK1_LSB +: BANK_W];
        end
        OFF_SET: begin
          next_st.dout[pwdata[3:0]] = 1'b1;
        end
        OFF_CLR: begin
          next_st.dout[pwdata[3:0]] = 1'b0;
        end
        OFF_COND: begin
          next_st.dout[pwdata[3:0]] = |pwdata[31:COND_OP_LSB];
        end
        OFF_OUT_RB: next_st.osel  = pwdata[3:0];
        OFF_IN_RD:  next_st.isel  = pwdata[3:0];
        OFF_POL:    next_st.pol   = pwdata[DIO_W-1:0];
        OFF_BANK:   next_st.bsel  = pwdata[SEL_LSB];
        OFF_DTRIP: begin
          // A new combination replaces any pending one
          next_st.dmask = pwdata[DIO_W-1:0];
          next_st.dlvl  = pwdata[LVL_LSB +: DIO_W];
          next_st.dwait = 1'b1;
        end
        OFF_AICFG: begin
          next_st.diff  = pwdata[DIFF_BIT];
          next_st.airng = pwdata[AIRNG_LSB +: RNG_W];
        end
        OFF_AOCFG: next_st.aorng = pwdata[RNG_W-1:0];
        OFF_ATRIP: begin
          next_st.tch    = new_ch;
          next_st.tdir   = pwdata[DIR_BIT];
          next_st.thr    = new_thr;
          next_st.await_ = !amet_new;
        end
        OFF_AOSET: begin
          next_st.dac_wr   = 1'b1;
          next_st.dac_ch   = new_ch;
          next_st.dac_code = new_code;
        end
        OFF_AO_RB: next_st.aosel = new_ch;
        OFF_AI_RD: next_st.aisel = new_ch;
        OFF_AI_INT: next_st.aisel = new_ch;
        default: begin
          // Unmapped writes change nothing
        end
      endcase
    end

    // Read data is built in setup so it is registered for the access edge
    if (psel && !penable) begin
      next_st.pready  = 1'b1;
      next_st.pslverr = 1'b0;
      next_st.prdata  = '0;
      case (paddr)
        OFF_DOUT:   next_st.prdata[DIO_W-1:0] = st.dout;
        OFF_SET:    next_st.prdata = '0;
        OFF_CLR:    next_st.prdata = '0;
        OFF_COND:   next_st.prdata = '0;
        OFF_OUT_RB: next_st.prdata[0] = st.dout[st.osel];
        OFF_IN_RD:  next_st.prdata[0] = act[st.isel];
        OFF_POL:    next_st.prdata[DIO_W-1:0] = st.pol;
        OFF_BANK:   next_st.prdata[BANK_W-1:0] = act[st.bsel*BANK_W +: BANK_W];
        OFF_DTRIP: begin
          next_st.prdata[DIO_W-1:0]        = st.dmask;
          next_st.prdata[LVL_LSB +: DIO_W] = st.dlvl;
        end
        OFF_AICFG: begin
          next_st.prdata[DIFF_BIT]              = st.diff;
          next_st.prdata[AIRNG_LSB +: RNG_W]    = st.airng;
        end
        OFF_AOCFG:  next_st.prdata[RNG_W-1:0] = st.aorng;
        OFF_ATRIP: begin
          next_st.prdata[SEL_LSB +: ACH_W]  = st.tch;
          next_st.prdata[DIR_BIT]           = st.tdir;
          next_st.prdata[CODE_LSB +: CODE_W] = st.thr;
        end
        OFF_AOSET:  next_st.prdata = '0;
        OFF_AO_RB:  next_st.prdata[CODE_W-1:0] = ao_rdata;
        OFF_AI_RD:  next_st.prdata[CODE_W-1:0] = ai_val;
        OFF_AI_INT: next_st.prdata[CODE_W+AI_SCALE_SH-1:0] = {ai_val, 3'b000};
        OFF_STATUS: begin
          next_st.prdata[ST_DHOLD] = st.dwait;
          next_st.prdata[ST_AHOLD] = st.await_;
        end
        default: begin
          // Unmapped address answers with an error and zero data
          next_st.pslverr = 1'b1;
        end
      endcase
    end
  end

  // State register; everything clears, so all outputs start off
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st      <= '0;
      st.dout <= DOUT_RST;
      st.pol  <= POL_RST;
      st.diff <= DIFF_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign prdata       = st.prdata;
  assign pready       = st.pready;
  assign pslverr      = st.pslverr;
  assign dout         = st.dout;
  assign ai_diff_mode = st.diff;
  assign ai_range     = st.airng;
  assign ao_range     = st.aorng;
  assign dac_wr       = st.dac_wr;
  assign dac_ch       = st.dac_ch;
  assign dac_code     = st.dac_code;
  assign digital_hold = st.dwait;
  assign voltage_hold = st.await_;

  // Set command turns the addressed output on one edge later
  set_bit_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_acc && paddr == OFF_SET) |=> dout[$past(pwdata[3:0])])
    else $error("set command did not turn output on");

  // Clear command turns the addressed output off
  clear_bit_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_acc && paddr == OFF_CLR) |=> !dout[$past(pwdata[3:0])])
    else $error("clear command did not turn output off");

  // Conditional write follows whether the operand is zero
  cond_write_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_acc && paddr == OFF_COND) |=>
      dout[$past(pwdata[3:0])] == ($past(pwdata[31:4]) != 28'h0000000))
    else $error("conditional write gave wrong output level");

  // Bank write loads both banks from their operands
  bank_write_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_acc && paddr == OFF_DOUT) |=> dout == $past(pwdata[15:0]))
    else $error("bank write did not load outputs");

  // Output readback reports the selected output
  out_readback_a: assert property (@(posedge mclk) disable iff (rst)
    (rd_setup && paddr == OFF_OUT_RB) |=> prdata[0] == dout[st.osel] && pready)
    else $error("output readback wrong");

  // Single input read honours the active-level setting
  in_level_a: assert property (@(posedge mclk) disable iff (rst)
    (rd_setup && paddr == OFF_IN_RD) |=>
      prdata[0] == $past(din[st.isel] ^ st.pol[st.isel]))
    else $error("input read ignores active level");

  // Digital hold releases one edge after its combination is met
  dhold_release_a: assert property (@(posedge mclk) disable iff (rst)
    (digital_hold && dmet && !(wr_acc && paddr == OFF_DTRIP)) |=> !digital_hold)
    else $error("digital hold did not release");

  // Integer input code is eight times the voltage code
  ai_scale_a: assert property (@(posedge mclk) disable iff (rst)
    (rd_setup && paddr == OFF_AI_INT && $stable(adc_code)) |=>
      prdata == {17'h00000, $past(ai_val), 3'b000})
    else $error("integer input code not scaled by eight");

  // A trip armed with its condition already met never holds
  atrip_pass_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_acc && paddr == OFF_ATRIP && amet_new) |=> !voltage_hold)
    else $error("analog trip held although condition met");

  // Output write pulses the converter with the written code
  dac_write_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_acc && paddr == OFF_AOSET) |=>
      dac_wr && dac_code == $past(new_code) ##1 !dac_wr)
    else $error("analog output write not passed on");

  // Bank status read reports the chosen bank after level mapping
  bank_status_a: assert property (@(posedge mclk) disable iff (rst)
    (rd_setup && paddr == OFF_BANK) |=> prdata[7:0] ==
      $past(st.bsel ? (din[15:8] ^ st.pol[15:8]) : (din[7:0] ^ st.pol[7:0])))
    else $error("bank status read wrong");

  // Analog hold releases one edge after its condition is met
  ahold_release_a: assert property (@(posedge mclk) disable iff (rst)
    (voltage_hold && amet && !(wr_acc && paddr == OFF_ATRIP)) |=> !voltage_hold)
    else $error("analog hold did not release");

  // Input mode write selects single-ended or differential
  input_mode_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_acc && paddr == OFF_AICFG) |=> ai_diff_mode == $past(pwdata[DIFF_BIT]))
    else $error("input mode not taken");

endmodule : io_cmd

// file: field_model.sv
/*
  Field-side model: switches on the digital inputs, sensors on the analog
  inputs and an actuator that keeps each analog output setpoint.
  Assumes the bench chooses the switch levels and sensor codes.
*/
`timescale 1ns/10ps
module field_model
  import io_cmd_pkg::*;
(
  input  wire logic                    mclk,     // Block clock
  input  wire logic [DIO_W-1:0]        din_set,  // Wanted switch levels
  input  wire logic [ACH_N*CODE_W-1:0] adc_set,  // Wanted sensor codes
  input  wire logic                    dac_wr,   // Output update pulse
  input  wire logic [ACH_W-1:0]        dac_ch,   // Channel updated
  input  wire logic [CODE_W-1:0]       dac_code, // Code updated
  output logic      [DIO_W-1:0]        din,      // Switch levels seen
  output logic      [ACH_N*CODE_W-1:0] adc_code, // Converted codes
  output logic      [CODE_W-1:0]       ao_level [ACH_N] // Actuator setpoints
);
  // Sensors lag the request by one edge, as a real front end would
  always_ff @(posedge mclk) begin
    din      <= din_set;
    adc_code <= adc_set;
    if (dac_wr) begin
      ao_level[dac_ch] <= dac_code; // Only a pulse moves the actuator
    end
  end
endmodule : field_model

// file: digital_analog_io_commands_test.sv
/*
  Self-checking bench for the I/O command block over APB.
  Assumes the field model on the pins; any APB wait state is flagged.
*/
`timescale 1ns/10ps
module digital_analog_io_commands_test;
  import io_cmd_pkg::*;
  logic                    mclk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]              paddr;
  logic [31:0]             pwdata, prdata, q;
  logic [DIO_W-1:0]        din, dout, din_set;
  logic [ACH_N*CODE_W-1:0] adc_code, adc_set;
  logic                    ai_diff_mode, dac_wr, digital_hold, voltage_hold, last_err;
  logic [RNG_W-1:0]        ai_range, ao_range;
  logic [ACH_W-1:0]        dac_ch;
  logic [CODE_W-1:0]       dac_code;
  logic [CODE_W-1:0]       ao_level [ACH_N];
  int                      err_total, comparisons, cyc, n;

  io_cmd u_io_cmd (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .din(din), .dout(dout), .adc_code(adc_code), .ai_diff_mode(ai_diff_mode),
    .ai_range(ai_range), .ao_range(ao_range), .dac_wr(dac_wr), .dac_ch(dac_ch),
    .dac_code(dac_code), .digital_hold(digital_hold), .voltage_hold(voltage_hold));
  field_model u_field_model (.mclk(mclk), .din_set(din_set), .adc_set(adc_set),
    .dac_wr(dac_wr), .dac_ch(dac_ch), .dac_code(dac_code), .din(din),
    .adc_code(adc_code), .ao_level(ao_level));

  // Free-running 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 5000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1);
    q        = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k != 1) chk("pready wait states", 32'h1, k);
    // Step clear of the answering edge so later looks see settled outputs
    #1;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Let c edges pass and step clear of the edge
  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask : tick

  task automatic t_outputs;
    chk("dout reset", 16'h0000, dout);
    wr(OFF_SET, 32'h2);
    wr(OFF_SET, 32'h1);
    wr(OFF_SET, 32'hf);
    chk("dout after write edge", 16'h8006, dout);
    tick(1);
    wr(OFF_CLR, 32'h1);
    tick(1);
    chk("dout set clear", 16'h8004, dout);
    wr(OFF_COND, 32'h0000_0053);
    wr(OFF_COND, 32'h0000_0002);
    tick(1);
    chk("dout cond", 16'h8008, dout);
    wr(OFF_OUT_RB, 32'h3);
    rd(OFF_OUT_RB);
    chk("readback on", 32'h1, {31'h0, q[0]});
    wr(OFF_OUT_RB, 32'h2);
    rd(OFF_OUT_RB);
    chk("readback off", 32'h0, {31'h0, q[0]});
    wr(OFF_DOUT, 32'h0000_0006);
    tick(1);
    chk("bank0 write", 16'h0006, dout);
    wr(OFF_DOUT, 32'h0000_0700);
    tick(1);
    chk("bank1 write", 16'h0700, dout);
    rd(OFF_DOUT);
    chk("bank read", 32'h0700, {16'h0, q[15:0]});
    $display("test outputs done");
  endtask : t_outputs

  task automatic t_inputs;
    din_set <= 16'h8045;
    wr(OFF_IN_RD, 32'hf);
    rd(OFF_IN_RD);
    chk("input 15", 32'h1, {31'h0, q[0]});
    wr(OFF_IN_RD, 32'h1);
    rd(OFF_IN_RD);
    chk("input 1", 32'h0, {31'h0, q[0]});
    wr(OFF_POL, 32'h0000_0002);
    rd(OFF_IN_RD);
    chk("input 1 inverted", 32'h1, {31'h0, q[0]});
    wr(OFF_BANK, 32'h0);
    rd(OFF_BANK);
    chk("bank 0 status", 32'h47, {24'h0, q[7:0]});
    wr(OFF_BANK, 32'h1);
    rd(OFF_BANK);
    chk("bank 1 status", 32'h80, {24'h0, q[7:0]});
    wr(OFF_POL, 32'h0);
    wr(OFF_DTRIP, 32'h0080_00c0);
    tick(1);
    chk("dhold armed", 32'h1, {31'h0, digital_hold});
    din_set <= 16'h0080;
    for (n = 0; n < 10 && digital_hold !== 1'b0; n++) @(posedge mclk);
    chk("dhold released", 32'h0, {31'h0, digital_hold});
    $display("test inputs done");
  endtask : t_inputs

  task automatic t_analog;
    adc_set <= {12'h0, 12'h0, 12'h123, 12'h0, 12'hfff, 12'h0, 12'h100, 12'h0};
    wr(OFF_AI_RD, 32'h3);
    rd(OFF_AI_RD);
    chk("ain code", 32'hfff, q);
    rd(OFF_AI_INT);
    chk("ain int full", 32'd32760, q);
    wr(OFF_AI_RD, 32'h5);
    rd(OFF_AI_INT);
    chk("ain int", 32'h123 * 8, q);
    wr(OFF_AICFG, 32'h5);
    tick(1);
    chk("diff mode", 32'h1, {31'h0, ai_diff_mode});
    chk("ain range", 32'h2, {30'h0, ai_range});
    wr(OFF_AI_RD, 32'h5);
    rd(OFF_AI_RD);
    chk("diff channel trim", 32'h100, q);
    wr(OFF_AICFG, 32'h0);
    wr(OFF_ATRIP, 32'h0200_0001);
    tick(1);
    chk("rise armed", 32'h1, {31'h0, voltage_hold});
    adc_set[23:12] <= 12'h300;
    for (n = 0; n < 10 && voltage_hold !== 1'b0; n++) @(posedge mclk);
    chk("rise released", 32'h0, {31'h0, voltage_hold});
    wr(OFF_ATRIP, 32'h0400_0011);
    tick(2);
    chk("already below", 32'h0, {31'h0, voltage_hold});
    wr(OFF_ATRIP, 32'h0200_0011);
    tick(1);
    chk("fall armed", 32'h1, {31'h0, voltage_hold});
    adc_set[23:12] <= 12'h100;
    for (n = 0; n < 10 && voltage_hold !== 1'b0; n++) @(posedge mclk);
    chk("fall released", 32'h0, {31'h0, voltage_hold});
    wr(OFF_AOSET, 32'h0abc_0007);
    tick(2);
    chk("actuator level", 32'habc, {20'h0, ao_level[7]});
    wr(OFF_AO_RB, 32'h7);
    rd(OFF_AO_RB);
    chk("aout readback", 32'habc, {20'h0, q[11:0]});
    wr(OFF_AOCFG, 32'h3);
    tick(1);
    chk("aout range", 32'h3, {30'h0, ao_range});
    rd(8'hfc);
    chk("unmapped err", 32'h1, {31'h0, last_err});
    $display("test analog done");
  endtask : t_analog

  // Main sequence: reset for five cycles, then each scenario in turn
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    din_set = 16'h0000;
    adc_set = '0;
    err_total = 0;
    comparisons = 0;
    cyc = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    tick(1);
    t_outputs();
    t_inputs();
    t_analog();
    tally_and_finish();
  end
endmodule : digital_analog_io_commands_test
